//--- core/lce_cfg.svh
// constants for the serial command engine of the segment lcd controller
// Function
// - reset pin low 12 clocks resets device
// - reset clears modes, blanks outputs, blocks input
// - shift serial_in msb first, eight bits per byte
// - select fall unblocks input, clears counter, pointer
// - eighth clock blocks, samples type, loads byte
// - select rise copies memory into latch
// - pause skips one latch update, keeps pointer
// - mux_sel picks four, static, three, two
// - bias_sel is only stored and read back in status, drives no output
// - frame_div_sel divides by 2^7,8,9,11
// - synchronized transfer waits for drive cycle
// - blink on with rate, blink off
// - display off blanks, on shows latch
// - decoder routes data bytes before memory
// - load pointer from pointer_imm
// - write, or, and display word, increment
// - write, or, and blink word, increment
// - clear commands zero memory and pointer
// - pointer wraps 31 to 0
// - blink off phase masks blinking bits
`ifndef LCE_CFG_SVH
`define LCE_CFG_SVH
// reset pin filter length in oscillator clocks
`define LCE_RST_MIN_CYC 4'hC
// fixed command codes
`define LCE_OP_DISP_OFF 8'h00
`define LCE_OP_DISP_ON 8'h11
`define LCE_OP_DEC_OFF 8'h14
`define LCE_OP_DEC_ON 8'h15
`define LCE_OP_BLINK_OFF 8'h18
`define LCE_OP_BLINK_ON 7'h0D
`define LCE_OP_CLR_DMEM 8'h20
`define LCE_OP_CLR_BMEM 8'h21
`define LCE_OP_UNSYNC 8'h30
`define LCE_OP_SYNC 8'h31
`define LCE_OP_PAUSE 8'h38
// grouped command codes, matched on their upper bits
`define LCE_OP_MODE 3'h2
`define LCE_OP_PTR 3'h7
`define LCE_OP_WR_DMEM 4'hD
`define LCE_OP_OR_DMEM 4'hB
`define LCE_OP_AND_DMEM 4'h9
`define LCE_OP_WR_BMEM 4'hC
`define LCE_OP_OR_BMEM 4'hA
`define LCE_OP_AND_BMEM 4'h8
// frame divider terminal counts
`define LCE_FDIV_TOP0 11'h07F
`define LCE_FDIV_TOP1 11'h0FF
`define LCE_FDIV_TOP2 11'h1FF
`define LCE_FDIV_TOP3 11'h7FF
// bus register byte offsets
`define LCE_REG_STATUS 4'h0
`define LCE_REG_PEEK_ADR 4'h4
`define LCE_REG_PEEK_DAT 4'h8
`endif

//--- core/lce_engine.sv
// serial command and data engine of a segment lcd controller
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "lce_cfg.svh"
module lce_engine (
	// clock (oscillator) and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// serial host link pins
	input wire logic reset_n_i,
	input wire logic select_n_i,
	input wire logic shift_clock_n_i,
	input wire logic serial_in_i,
	input wire logic command_data_sel_i,
	output logic input_blocked_n_o,
	output logic input_blocked_oe_o,
	// lcd drive levels
	output logic [31:0] seg_out_o,
	output logic [3:0] common_out_o,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o
);
	// synchronised pins
	logic [4:0] pins_s;
	logic rst_pin_n_s;
	logic cs_n_s;
	logic sck_n_s;
	logic si_s;
	logic cd_s;
	logic sck_prev_q; // edge finder for the shift clock
	logic cs_prev_q; // edge finder for select
	logic [3:0] rst_cnt_q; // low-time counter for the reset pin
	logic init; // block reset, bus or pin

	// serial front end
	lce_pkg::lce_state_t state_q;
	logic [7:0] sr_q; // serial shift register
	logic [2:0] bit_cnt_q;
	logic cd_q; // byte type caught at the eighth edge
	logic [7:0] data_q; // byte being spread over memory words
	logic [3:0] steps_q; // memory words still to write
	logic busy_n_q;

	// settings
	logic [1:0] mux_sel_q;
	logic bias_sel_q;
	logic [1:0] frame_div_sel_q;
	logic blink_en_q;
	logic blink_rate_sel_q;
	logic disp_on_q;
	logic dec_en_q;

	// memories, pointer, latch
	lce_pkg::lce_word_t dmem_q [32];
	lce_pkg::lce_word_t bmem_q [32];
	lce_pkg::lce_word_t dlat_q [32];
	lce_pkg::lce_word_t blat_q [32];
	logic [4:0] ptr_q;
	logic sync_mode_q;
	logic pause_q; // next select rise skips the copy
	logic resume_q; // next select fall keeps the pointer
	logic pend_q; // copy waiting for the drive cycle

	// drive timing
	logic [10:0] div_cnt_q;
	logic [1:0] com_idx_q;
	logic [16:0] blink_cnt_q;

	// bus
	logic [4:0] peek_adr_q;

	// combinational helpers
	logic sck_rise;
	logic cs_rise;
	logic [7:0] sr_next;
	logic cmd_fire;
	logic data_step;
	logic [7:0] byte_v;
	logic [10:0] div_top;
	logic frame_tick;
	logic ac_tick;
	logic [1:0] com_last;
	logic [2:0] bits_per_word;
	logic [3:0] word_steps;
	logic [3:0] word_mask;
	logic blink_off;
	logic copy_now;
	logic bus_req;

	// seven-segment glyphs, a in bit 0 through g in bit 6
	function automatic logic [7:0] glyph(input logic [3:0] v);
		case (v)
			4'h0: glyph = 8'h3F;
			4'h1: glyph = 8'h06;
			4'h2: glyph = 8'h5B;
			4'h3: glyph = 8'h4F;
			4'h4: glyph = 8'h66;
			4'h5: glyph = 8'h6D;
			4'h6: glyph = 8'h7D;
			4'h7: glyph = 8'h07;
			4'h8: glyph = 8'h7F;
			4'h9: glyph = 8'h6F;
			4'hA: glyph = 8'h77;
			4'hB: glyph = 8'h7C;
			4'hC: glyph = 8'h39;
			4'hD: glyph = 8'h5E;
			4'hE: glyph = 8'h79;
			default: glyph = 8'h71;
		endcase
	endfunction

	// every pin crosses two flops before use
	lce_sync #(.W(5), .RV(5'h1F)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({reset_n_i, select_n_i, shift_clock_n_i, serial_in_i, command_data_sel_i}),
		.q_o(pins_s)
	);
	assign {rst_pin_n_s, cs_n_s, sck_n_s, si_s, cd_s} = pins_s;

	// reset pin must stay low a full 12 clocks; glitches do nothing
	always_ff @(posedge clk_i)
	begin
		if (rst_i || rst_pin_n_s)
			rst_cnt_q <= 4'h0;
		else if (rst_cnt_q != `LCE_RST_MIN_CYC)
			rst_cnt_q <= rst_cnt_q + 4'h1;
	end
	assign init = rst_i || (rst_cnt_q == `LCE_RST_MIN_CYC);

	// edge history of the synchronised link pins
	always_ff @(posedge clk_i)
	begin
		if (init)
		begin
			sck_prev_q <= 1'b1;
			cs_prev_q <= 1'b1;
		end
		else
		begin
			sck_prev_q <= sck_n_s;
			cs_prev_q <= cs_n_s;
		end
	end
	assign sck_rise = sck_n_s && !sck_prev_q;
	assign cs_rise = cs_n_s && !cs_prev_q;
	assign sr_next = {sr_q[6:0], si_s};
	assign cmd_fire = (state_q == lce_pkg::LCE_EXEC) && cd_q;
	assign data_step = (state_q == lce_pkg::LCE_EXEC) && !cd_q;
	assign byte_v = sr_q;

	// word packing follows the number of commons
	always_comb
	begin
		case (mux_sel_q)
			2'b00: bits_per_word = 3'h4;
			2'b10: bits_per_word = 3'h3;
			2'b11: bits_per_word = 3'h2;
			default: bits_per_word = 3'h1;
		endcase
		case (mux_sel_q)
			2'b00: word_steps = 4'h2;
			2'b10: word_steps = 4'h3;
			2'b11: word_steps = 4'h4;
			default: word_steps = 4'h8;
		endcase
		case (mux_sel_q)
			2'b00: word_mask = 4'hF;
			2'b10: word_mask = 4'h7;
			2'b11: word_mask = 4'h3;
			default: word_mask = 4'h1;
		endcase
		com_last = 2'(bits_per_word - 3'h1);
	end

	// serial sequencer: select, shift, execute
	always_ff @(posedge clk_i)
	begin
		if (init)
		begin
			state_q <= lce_pkg::LCE_IDLE;
			busy_n_q <= 1'b0;
			sr_q <= 8'h00;
			bit_cnt_q <= 3'h0;
			cd_q <= 1'b0;
			data_q <= 8'h00;
			steps_q <= 4'h0;
		end
		else
		begin
			case (state_q)
				lce_pkg::LCE_IDLE:
				begin
					busy_n_q <= 1'b0;
					if (!cs_n_s)
						state_q <= lce_pkg::LCE_SEL;
				end
				lce_pkg::LCE_SEL:
				begin
					bit_cnt_q <= 3'h0;
					busy_n_q <= 1'b1;
					state_q <= lce_pkg::LCE_SHIFT;
				end
				lce_pkg::LCE_SHIFT:
				begin
					if (cs_n_s)
					begin
						busy_n_q <= 1'b0;
						state_q <= lce_pkg::LCE_IDLE;
					end
					else if (sck_rise)
					begin
						sr_q <= sr_next;
						bit_cnt_q <= bit_cnt_q + 3'h1;
						if (bit_cnt_q == 3'h7)
						begin
							busy_n_q <= 1'b0;
							cd_q <= cd_s;
							data_q <= dec_en_q ? glyph(sr_next[3:0]) : sr_next;
							steps_q <= word_steps;
							state_q <= lce_pkg::LCE_EXEC;
						end
					end
				end
				lce_pkg::LCE_EXEC:
				begin
					// commands take one cycle, data one cycle per word
					if (cd_q || steps_q == 4'h1)
					begin
						busy_n_q <= 1'b1;
						state_q <= lce_pkg::LCE_SHIFT;
					end
					steps_q <= steps_q - 4'h1;
					data_q <= data_q >> bits_per_word;
				end
				default:
					state_q <= lce_pkg::LCE_IDLE;
			endcase
		end
	end

	// mode, blink, display and decoder settings
	always_ff @(posedge clk_i)
	begin
		if (init)
		begin
			mux_sel_q <= 2'b00;
			bias_sel_q <= 1'b0;
			frame_div_sel_q <= 2'b00;
			blink_en_q <= 1'b0;
			blink_rate_sel_q <= 1'b0;
			disp_on_q <= 1'b0;
			dec_en_q <= 1'b0;
		end
		else if (cmd_fire)
		begin
			if (byte_v[7:5] == `LCE_OP_MODE)
			begin
				bias_sel_q <= byte_v[4];
				frame_div_sel_q <= byte_v[3:2];
				mux_sel_q <= byte_v[1:0];
			end
			if (byte_v[7:1] == `LCE_OP_BLINK_ON)
			begin
				blink_en_q <= 1'b1;
				blink_rate_sel_q <= byte_v[0];
			end
			if (byte_v == `LCE_OP_BLINK_OFF)
				blink_en_q <= 1'b0;
			if (byte_v == `LCE_OP_DISP_ON)
				disp_on_q <= 1'b1;
			if (byte_v == `LCE_OP_DISP_OFF)
				disp_on_q <= 1'b0;
			if (byte_v == `LCE_OP_DEC_ON)
				dec_en_q <= 1'b1;
			if (byte_v == `LCE_OP_DEC_OFF)
				dec_en_q <= 1'b0;
		end
	end

	// memories and the shared pointer; 5-bit arithmetic wraps 31 to 0
	always_ff @(posedge clk_i)
	begin
		if (init)
		begin
			ptr_q <= 5'h00;
			for (int i = 0; i < 32; i++)
			begin
				dmem_q[i] <= 4'h0;
				bmem_q[i] <= 4'h0;
			end
		end
		else if (state_q == lce_pkg::LCE_SEL)
		begin
			if (!resume_q)
				ptr_q <= 5'h00;
		end
		else if (data_step)
		begin
			dmem_q[ptr_q] <= data_q[3:0] & word_mask;
			ptr_q <= ptr_q + 5'h01;
		end
		else if (cmd_fire)
		begin
			// one opcode per byte, so the branches never overlap
			if (byte_v[7:5] == `LCE_OP_PTR)
				ptr_q <= byte_v[4:0];
			if (byte_v[7:4] == `LCE_OP_WR_DMEM)
				dmem_q[ptr_q] <= byte_v[3:0];
			if (byte_v[7:4] == `LCE_OP_OR_DMEM)
				dmem_q[ptr_q] <= dmem_q[ptr_q] | byte_v[3:0];
			if (byte_v[7:4] == `LCE_OP_AND_DMEM)
				dmem_q[ptr_q] <= dmem_q[ptr_q] & byte_v[3:0];
			if (byte_v[7:4] == `LCE_OP_WR_BMEM)
				bmem_q[ptr_q] <= byte_v[3:0];
			if (byte_v[7:4] == `LCE_OP_OR_BMEM)
				bmem_q[ptr_q] <= bmem_q[ptr_q] | byte_v[3:0];
			if (byte_v[7:4] == `LCE_OP_AND_BMEM)
				bmem_q[ptr_q] <= bmem_q[ptr_q] & byte_v[3:0];
			if (byte_v[7:4] >= `LCE_OP_AND_BMEM && byte_v[7:4] <= `LCE_OP_WR_DMEM)
				ptr_q <= ptr_q + 5'h01;
			if (byte_v == `LCE_OP_CLR_DMEM)
			begin
				ptr_q <= 5'h00;
				for (int i = 0; i < 32; i++)
					dmem_q[i] <= 4'h0;
			end
			if (byte_v == `LCE_OP_CLR_BMEM)
			begin
				ptr_q <= 5'h00;
				for (int i = 0; i < 32; i++)
					bmem_q[i] <= 4'h0;
			end
		end
	end

	// latch transfer: immediate, synchronised or paused
	assign copy_now = (cs_rise && !pause_q && !sync_mode_q) || (pend_q && ac_tick);
	always_ff @(posedge clk_i)
	begin
		if (init)
		begin
			sync_mode_q <= 1'b0;
			pause_q <= 1'b0;
			resume_q <= 1'b0;
			pend_q <= 1'b0;
			for (int i = 0; i < 32; i++)
			begin
				dlat_q[i] <= 4'h0;
				blat_q[i] <= 4'h0;
			end
		end
		else
		begin
			if (cmd_fire && byte_v == `LCE_OP_SYNC)
				sync_mode_q <= 1'b1;
			if (cmd_fire && byte_v == `LCE_OP_UNSYNC)
				sync_mode_q <= 1'b0;
			if (cs_rise)
			begin
				// a paused rise skips the copy once and arms pointer keep
				pause_q <= 1'b0;
				resume_q <= pause_q;
				if (!pause_q && sync_mode_q)
					pend_q <= 1'b1;
			end
			else if (cmd_fire && byte_v == `LCE_OP_PAUSE)
				pause_q <= 1'b1;
			if (state_q == lce_pkg::LCE_SEL)
				resume_q <= 1'b0;
			if (copy_now)
			begin
				if (!cs_rise)
					pend_q <= 1'b0;
				for (int i = 0; i < 32; i++)
				begin
					dlat_q[i] <= dmem_q[i];
					blat_q[i] <= bmem_q[i];
				end
			end
		end
	end

	// frame divider, common scan and blink period
	always_comb
	begin
		case (frame_div_sel_q)
			2'b00: div_top = `LCE_FDIV_TOP0;
			2'b01: div_top = `LCE_FDIV_TOP1;
			2'b10: div_top = `LCE_FDIV_TOP2;
			default: div_top = `LCE_FDIV_TOP3;
		endcase
	end
	assign frame_tick = (div_cnt_q >= div_top);
	assign ac_tick = frame_tick && (com_idx_q >= com_last);
	assign blink_off = blink_en_q && (blink_rate_sel_q ? blink_cnt_q[15] : blink_cnt_q[16]);
	always_ff @(posedge clk_i)
	begin
		if (init)
		begin
			div_cnt_q <= 11'h000;
			com_idx_q <= 2'h0;
			blink_cnt_q <= 17'h00000;
		end
		else
		begin
			blink_cnt_q <= blink_cnt_q + 17'h00001;
			div_cnt_q <= frame_tick ? 11'h000 : div_cnt_q + 11'h001;
			if (frame_tick)
				com_idx_q <= (com_idx_q >= com_last) ? 2'h0 : com_idx_q + 2'h1;
		end
	end

	// drive levels; blanked as all ones, the non-select relation
	always_ff @(posedge clk_i)
	begin
		if (init || !disp_on_q)
		begin
			seg_out_o <= 32'hFFFFFFFF;
			common_out_o <= 4'hF;
		end
		else
		begin
			common_out_o <= 4'h1 << com_idx_q;
			for (int i = 0; i < 32; i++)
				seg_out_o[i] <= dlat_q[i][com_idx_q] & !(blat_q[i][com_idx_q] && blink_off);
		end
	end

	// busy pin, driven only while selected
	always_ff @(posedge clk_i)
	begin
		if (init)
		begin
			input_blocked_n_o <= 1'b0;
			input_blocked_oe_o <= 1'b0;
		end
		else
		begin
			input_blocked_n_o <= busy_n_q;
			input_blocked_oe_o <= !cs_n_s;
		end
	end

	// wishbone slave: one wait state, unmapped reads give zero
	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	always_ff @(posedge clk_i)
	begin
		if (init)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			peek_adr_q <= 5'h00;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= 32'h00000000;
			if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == `LCE_REG_PEEK_ADR)
				peek_adr_q <= wb_dat_i[4:0]; // taken at the ack edge, while the master still holds it
			if (bus_req && !wb_we_i)
			begin
				case (wb_adr_i)
					`LCE_REG_STATUS:
						wb_dat_o <= {7'h00, ptr_q, 6'h00, resume_q, pend_q, pause_q,
							sync_mode_q, dec_en_q, disp_on_q, blink_rate_sel_q, blink_en_q,
							frame_div_sel_q, bias_sel_q, mux_sel_q, busy_n_q};
					`LCE_REG_PEEK_ADR:
						wb_dat_o <= {27'h0000000, peek_adr_q};
					`LCE_REG_PEEK_DAT:
						wb_dat_o <= {20'h00000, dlat_q[peek_adr_q], bmem_q[peek_adr_q], dmem_q[peek_adr_q]};
					default:
						wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // lce_engine

//--- core/lce_pkg.sv
// types shared by the serial command engine
package lce_pkg;
	// serial front end sequencing
	typedef enum logic [1:0] {
		LCE_IDLE,
		LCE_SEL,
		LCE_SHIFT,
		LCE_EXEC
	} lce_state_t;
	// four bit memory word
	typedef logic [3:0] lce_word_t;
endpackage

//--- core/lce_sync.sv
// two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module lce_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RV = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// asynchronous levels in, synchronised levels out
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q; // first stage, read only by the second

	// two stages; reset to the idle pin level
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			meta_q <= RV;
			q_o <= RV;
		end
		else
		begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule // lce_sync

//--- sim/lce_engine_sva.sv
// assertion checker bound to the lcd serial command engine
`timescale 1ns/1ps
module lce_engine_sva (
	// watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic reset_n_i,
	input wire logic select_n_i,
	input wire logic input_blocked_n_o,
	input wire logic input_blocked_oe_o,
	input wire logic [31:0] seg_out_o,
	input wire logic [3:0] common_out_o,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// clocks the reset pin has stayed low, saturating
	logic [4:0] low_q;
	always_ff @(posedge clk_i)
	begin
		if (rst_i || reset_n_i)
			low_q <= 5'h00;
		else if (low_q != 5'h1F)
			low_q <= low_q + 5'h01;
	end
	a_reset_blank: assert property (disable iff (1'b0)
		rst_i |=> seg_out_o == '1 && common_out_o == 4'hF && !input_blocked_n_o)
		else $error("outputs not blank in reset");
	a_pin_reset: assert property (low_q == 5'h14 |-> seg_out_o == '1 && !input_blocked_n_o)
		else $error("pin reset not taken");
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o
		&& !(wb_adr_i inside {4'h0, 4'h4, 4'h8}) |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_select_unblock: assert property ($fell(select_n_i) |-> ##[2:12] input_blocked_n_o)
		else $error("select did not unblock");
	a_busy_release: assert property ($rose(select_n_i) |-> ##[1:6] !input_blocked_oe_o)
		else $error("busy still driven");
	a_common_shape: assert property ($onehot(common_out_o) || common_out_o == 4'hF)
		else $error("bad common pattern");
	a_blank_seg: assert property (common_out_o == 4'hF |-> seg_out_o == '1)
		else $error("segments not blank");
endmodule // lce_engine_sva
bind lce_engine lce_engine_sva u_sva (.clk_i, .rst_i, .reset_n_i, .select_n_i, .input_blocked_n_o,
	.input_blocked_oe_o, .seg_out_o, .common_out_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_o, .wb_ack_o);

//--- sim/lce_host.sv
// host model driving the serial link of the lcd engine
`timescale 1ns/1ps
module lce_host (
	// clock and busy line as seen on the wire
	input wire logic clk_i,
	input wire logic busy_w_i,
	input wire logic busy_oe_i,
	// link pins
	output logic reset_n_o,
	output logic select_n_o,
	output logic sclk_n_o,
	output logic sdata_o,
	output logic cd_o
);
	initial
	begin
		reset_n_o = 1'b1;
		select_n_o = 1'b1;
		sclk_n_o = 1'b1;
		sdata_o = 1'b0;
		cd_o = 1'b0;
	end
	// half of the 800 ns shift clock period
	task automatic half();
		repeat (4) @(posedge clk_i);
	endtask
	// shift clocks with select high, which must be dropped
	task automatic junk(input int n);
		repeat (n)
		begin
			sclk_n_o <= 1'b0;
			sdata_o <= ~sdata_o;
			half();
			sclk_n_o <= 1'b1;
			half();
		end
	endtask
	// reset pin low for n clocks, device deselected
	task automatic pin_reset(input int n);
		reset_n_o <= 1'b0;
		repeat (n) @(posedge clk_i);
		reset_n_o <= 1'b1;
		repeat (20) @(posedge clk_i);
	endtask
	task automatic sel();
		select_n_o <= 1'b0;
		half();
	endtask
	// raised only between whole bytes
	task automatic desel();
		select_n_o <= 1'b1;
		repeat (24) @(posedge clk_i);
	endtask
	// one byte msb first; waits for unblock before the first bit
	task automatic send(input logic [7:0] b, input logic c);
		while (!(busy_oe_i && busy_w_i)) @(posedge clk_i);
		cd_o <= c;
		for (int i = 7; i >= 0; i--)
		begin
			sclk_n_o <= 1'b0;
			sdata_o <= b[i];
			half();
			sclk_n_o <= 1'b1;
			if (i > 0)
				half();
		end
		// the data line toggles so a stale bit is never seen
		while (busy_w_i) @(posedge clk_i);
		sdata_o <= ~sdata_o;
	endtask
endmodule // lce_host

//--- sim/tb_lce_engine.sv
// self-checking bench for the lcd serial command engine
`timescale 1ns/1ps
module tb_lce_engine;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [3:0] adr = 4'h0, com;
	logic [31:0] wdat = 32'h0, lfsr = 32'h28C47AAD, rdo, rd, seg, v;
	logic rn, sn, sc, sd, cd, bn, boe;
	logic [3:0] dm [32], bm [32], n;
	logic [4:0] ptr;
	// flag commands and the status bits 10:6 they leave
	logic [7:0] op [8] = '{8'h1B, 8'h1A, 8'h18, 8'h11, 8'h15, 8'h14, 8'h31, 8'h30};
	logic [4:0] ex [8] = '{5'h03, 5'h01, 5'h00, 5'h04, 5'h0C, 5'h04, 5'h14, 5'h04};
	logic [3:0] opc [6] = '{4'hD, 4'hB, 4'h9, 4'hC, 4'hA, 4'h8};
	int mismatches = 0, samples_checked = 0, cyc_n = 0, k;
	// busy line with a pull-up while released
	wire busy_w = boe ? bn : 1'b1;
	lce_host HOST (.clk_i, .busy_w_i(busy_w), .busy_oe_i(boe), .reset_n_o(rn), .select_n_o(sn),
		.sclk_n_o(sc), .sdata_o(sd), .cd_o(cd));
	lce_engine DUT (.clk_i, .rst_i, .reset_n_i(rn), .select_n_i(sn), .shift_clock_n_i(sc),
		.serial_in_i(sd), .command_data_sel_i(cd), .input_blocked_n_o(bn), .input_blocked_oe_o(boe),
		.seg_out_o(seg), .common_out_o(com), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdo), .wb_ack_o(ack));
	initial
		forever #50 clk_i = ~clk_i;
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	// expected word after a write, or, and step
	function automatic logic [3:0] f_op(input int k3, input logic [3:0] o, input logic [3:0] d);
		return (k3 == 0) ? d : (k3 == 1) ? (o | d) : (o & d);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// one classic wishbone cycle; waits for ack
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rd = rdo;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cmd(input logic [7:0] b);
		HOST.send(b, 1'b1);
	endtask
	task automatic pk(input logic [4:0] a, input logic [11:0] e);
		wb(1'b1, 4'h4, {27'h0, a});
		wb(1'b0, 4'h8, 32'h0);
		chk("peek", {20'h0, e}, rd);
	endtask
	always @(posedge clk_i)
	begin
		cyc_n++;
		if (cyc_n == 30000)
		begin
			mismatches++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		for (int i = 0; i < 32; i++)
		begin
			dm[i] = 4'h0;
			bm[i] = 4'h0;
		end
		wb(1'b0, 4'hC, 32'h0);
		chk("unmapped", 32'h0, rd);
		wb(1'b0, 4'h0, 32'h0);
		chk("status", 32'h0, rd & 32'h01F03FFE);
		HOST.sel();
		for (int m = 0; m < 4; m++)
		begin
			v = rnd();
			cmd({3'b010, v[0], v[2:1], m[1:0]});
			wb(1'b0, 4'h0, 32'h0);
			chk("mode", {26'h0, v[2:1], v[0], m[1:0], 1'b0}, rd & 32'h3E);
		end
		cmd(8'h40);
		for (int i = 0; i < 8; i++)
		begin
			cmd(op[i]);
			wb(1'b0, 4'h0, 32'h0);
			chk("flags", {21'h0, ex[i], 6'h0}, rd & 32'h7C0);
		end
		cmd(8'hFF);
		ptr = 5'h1F;
		for (int i = 0; i < 12; i++)
		begin
			v = rnd();
			k = v[10:8] % 6;
			n = v[3:0];
			cmd({opc[k], n});
			if (k < 3)
				dm[ptr] = f_op(k, dm[ptr], n);
			else
				bm[ptr] = f_op(k - 3, bm[ptr], n);
			ptr++;
			wb(1'b0, 4'h0, 32'h0);
			chk("ptr", {27'h0, ptr}, {27'h0, rd[24:20]});
		end
		for (int i = -1; i < 11; i++)
			pk(i[4:0], {4'h0, bm[i[4:0]], dm[i[4:0]]});
		HOST.desel();
		pk(5'h02, {dm[2], bm[2], dm[2]});
		HOST.junk(3);
		HOST.sel();
		wb(1'b0, 4'h0, 32'h0);
		chk("ptr", 32'h0, {27'h0, rd[24:20]});
		cmd(8'hE5);
		cmd(8'hD9);
		cmd(8'h38);
		HOST.desel();
		pk(5'h05, {dm[5], bm[5], 4'h9});
		HOST.sel();
		HOST.send(8'hA5, 1'b0);
		wb(1'b0, 4'h0, 32'h0);
		chk("ptr", 32'h8, {27'h0, rd[24:20]});
		HOST.desel();
		pk(5'h06, {4'h5, bm[6], 4'h5});
		pk(5'h07, {4'hA, bm[7], 4'hA});
		HOST.sel();
		cmd(8'h20);
		cmd(8'h21);
		wb(1'b0, 4'h0, 32'h0);
		chk("ptr", 32'h0, {27'h0, rd[24:20]});
		pk(5'h07, 12'hA00);
		// decoder on: glyph of 6 lights a,c,d,e,f,g, packed four bits a word
		cmd(8'h15);
		HOST.send(8'h06, 1'b0);
		cmd(8'h14);
		wb(1'b0, 4'h0, 32'h0);
		chk("ptr", 32'h2, {27'h0, rd[24:20]});
		// synchronised copy: select rises just after a scan starts, so the copy is far off
		cmd(8'h31);
		while (com !== 4'h8) @(posedge clk_i);
		while (com !== 4'h1) @(posedge clk_i);
		HOST.desel();
		pk(5'h00, {dm[0], 4'h0, 4'hD});
		repeat (600) @(posedge clk_i);
		pk(5'h00, 12'hD0D);
		pk(5'h01, 12'h707);
		HOST.sel();
		cmd(8'h00);
		// the blanked levels appear one edge after the busy line drops
		repeat (2) @(posedge clk_i);
		chk("seg", 32'hFFFFFFFF, seg);
		chk("com", 32'hF, {28'h0, com});
		cmd(8'h11);
		HOST.desel();
		HOST.pin_reset(5);
		wb(1'b0, 4'h0, 32'h0);
		chk("short", 32'h100, rd & 32'h100);
		HOST.pin_reset(20);
		wb(1'b0, 4'h0, 32'h0);
		chk("pinrst", 32'h0, rd & 32'h01F03FFE);
		give_verdict();
	end
endmodule // tb_lce_engine
